//--- verification/ccc_far_side.sv
/*
  far-side model of the core control block: nmi source and data-space peripheral.
  assumes a bench that calls pulse_nmi right after a rising edge, no command in flight.
*/
`timescale 1ns/1ps
`default_nettype none
module ccc_far_side (
  input wire logic pclk, // core clock
  input wire logic presetn, // reset, active low
  input wire logic [7:0] data_addr, // indirect data-space address
  input wire logic data_req, // indirect access strobe
  output logic nmi_n, // top-priority interrupt line, pulled up
  output logic [7:0] last_addr // last address the peripheral accepted
);
  // ==========================================================
  // nmi source
  initial nmi_n <= 1'b1; // pull-up keeps the line high when idle
  // pin moves just after a rising edge; the core still runs it through its synchroniser
  task automatic pulse_nmi(input int low_cycles);
    nmi_n <= 1'b0;
    repeat (low_cycles) @(posedge pclk);
    nmi_n <= 1'b1;
  endtask
  // ==========================================================
  // peripheral latch: takes the address only on the one-cycle strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr <= 8'h00;
    end else if (data_req) begin
      last_addr <= data_addr;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
/*
  self-checking bench of the core control block over apb, with a reference model.
  assumes the far-side model beside it; the bus master waits for pready as long as needed.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ccc_pkg::*;
  // ==========================================================
  // signals and model state
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nmi_n, data_req;
  logic [11:0] paddr, rom_addr;
  logic [31:0] pwdata, prdata;
  logic [7:0] data_addr, last_addr;
  int num_errors, cmp_count, seed;
  logic [32:0] exp_q[$]; // pending read results, oldest first
  logic [7:0] adr_q[$]; // pending indirect addresses
  logic [11:0] m_pc, m_stk[6];
  logic [2:0] m_dep;
  logic [1:0] m_mode, m_nret; // active mode, mode to resume after nmi
  logic m_c[4], m_z[4]; // flag pairs indexed by mode code
  logic [7:0] m_reg[5]; // ptr first, ptr second, slot a, slot b, acc
  logic [11:0] regs[5];
  localparam logic [11:0] A_CMD = {IDX_CMD, 2'b00};
  localparam logic [11:0] A_STAT = {IDX_STAT, 2'b00};
  localparam logic [11:0] A_STK = {IDX_STACK, 2'b00};

  ccc_core_ctrl #(.STACK_DEPTH(6)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nmi_n(nmi_n), .rom_addr(rom_addr),
    .data_addr(data_addr), .data_req(data_req));
  ccc_far_side i_far (.pclk(pclk), .presetn(presetn), .data_addr(data_addr),
    .data_req(data_req), .nmi_n(nmi_n), .last_addr(last_addr));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ==========================================================
  // comparison and verdict
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // bus master: setup, access held until pready seen high, release after that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is read at each rising edge; only the watchdog ends a wait that never ends
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // status word built from the model; rom_addr must mirror the pc
  task automatic rd_stat;
    rd(A_STAT, {12'h000, 1'b0, m_dep, m_z[m_mode], m_c[m_mode], m_mode, m_pc});
    check(33'(rom_addr), 33'(m_pc));
  endtask
  // ==========================================================
  // reference model of the stack and commands
  task automatic push;
    for (int i = 5; i > 0; i--) m_stk[i] = m_stk[i - 1];
    m_stk[0] = m_pc;
    if (m_dep < 3'd6) m_dep++;
  endtask
  task automatic op(input logic [3:0] o, input logic [11:0] arg, input logic [7:0] d);
    logic [8:0] s;
    logic oc;
    oc = m_c[m_mode];
    case (o)
      4'h1: m_pc = arg;
      4'h2: begin push(); m_pc = arg; end
      4'h3: m_pc = m_pc + {{4{arg[7]}}, arg[7:0]};
      4'h4, 4'h5: begin
        if (m_dep != 3'd0) begin
          m_pc = m_stk[0];
          for (int i = 0; i < 5; i++) m_stk[i] = m_stk[i + 1];
          m_dep--;
        end else m_pc++; // empty stack steps on
        if (o == 4'h5) m_mode = (m_mode == 2'b11) ? m_nret : 2'b00;
      end
      4'h6: if (m_mode == 2'b00) begin
        push(); m_pc = 12'hFF0 + {arg[1:0], 1'b0}; m_mode = 2'b01;
      end else m_pc++;
      default: m_pc++;
    endcase
    case (o)
      4'h7: begin s = m_reg[4] + d; m_reg[4] = s[7:0]; m_c[m_mode] = s[8]; end
      4'h8: begin m_c[m_mode] = m_reg[4] < d; m_reg[4] = m_reg[4] - d; end
      4'h9: m_reg[4] = m_reg[4] & d;
      4'hA: m_c[m_mode] = d[arg[2:0]];
      4'hB: begin m_c[m_mode] = m_reg[4][7]; m_reg[4] = {m_reg[4][6:0], oc}; end
      4'hC: adr_q.push_back(m_reg[arg[0]]);
      default: ;
    endcase
    if (o inside {4'h7, 4'h8, 4'h9, 4'hB}) m_z[m_mode] = (m_reg[4] == 8'h00);
    apb(1'b1, A_CMD, {8'h00, d, arg, o});
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    m_pc = RESET_VEC; m_mode = 2'b11; m_nret = 2'b00; m_dep = 3'd0;
    for (int i = 0; i < 6; i++) m_stk[i] = 12'h000;
    for (int i = 0; i < 4; i++) begin m_c[i] = 1'b0; m_z[i] = 1'b0; end
    for (int i = 0; i < 5; i++) m_reg[i] = REG_RST;
  endtask
  // ==========================================================
  // monitor: at the rising edge that ends an access or a strobe, pops the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1_FFFF_FFFF);
      else check({pslverr, prdata}, exp_q.pop_front());
    end
    if (data_req === 1'b1) begin
      if (adr_q.size() == 0) check(33'h000, 33'h1FF);
      else check(33'(data_addr), 33'(adr_q.pop_front()));
    end
  end
  initial begin
    #5_000_000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] v;
    num_errors = 0; cmp_count = 0; seed = 73486;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    presetn = 1'b0;
    regs = '{12'h200, 12'h204, 12'h208, 12'h20C, 12'h3FC};
    do_reset();
    rd_stat();
    for (int i = 0; i < 5; i++) begin
      rd(regs[i], {24'h0, REG_RST});
      v = $random(seed);
      apb(1'b1, regs[i], v);
      m_reg[i] = v[7:0];
      rd(regs[i], {24'h0, v[7:0]});
    end
    rd(A_CMD, 32'h0);
    rd(12'h004, 32'h0, 1'b1);
    apb(1'b1, A_STAT, $random(seed));
    op(4'h7, 12'h000, 8'hFF); // nmi pair takes the result
    rd_stat();
    op(4'h5, 12'h000, 8'h00); // interrupt_exit on empty stack: main, pc steps on
    rd_stat();
    apb(1'b1, regs[4], 32'h80); m_reg[4] = 8'h80;
    op(4'hB, 12'h000, 8'h00); rd_stat();
    op(4'hB, 12'h000, 8'h00); rd_stat();
    op(4'h8, 12'h000, 8'($random(seed))); rd_stat();
    op(4'h9, 12'h000, 8'($random(seed))); rd_stat();
    for (int i = 0; i < 8; i++) begin
      op(4'hA, i[11:0], 8'($random(seed))); rd_stat();
    end
    op(4'h6, 12'h002, 8'h00); rd_stat();
    op(4'h7, 12'h000, 8'($random(seed))); rd_stat();
    op(4'h6, 12'h001, 8'h00); rd_stat();
    op(4'h5, 12'h000, 8'h00); rd_stat();
    op(4'h1, 12'h123, 8'h00); op(4'h3, 12'h010, 8'h00); rd_stat();
    op(4'h3, 12'h0E0, 8'h00); op(4'h0, 12'h000, 8'h00); op(4'hF, 12'h000, 8'h00);
    rd_stat();
    op(4'h1, 12'hFFF, 8'h00); op(4'h0, 12'h000, 8'h00); rd_stat();
    for (int i = 0; i < 7; i++) op(4'h2, 12'h100 + 12'(i * 16), 8'h00);
    rd_stat();
    rd(A_STK, {20'h0, m_stk[0]});
    rd(regs[4], {24'h0, m_reg[4]});
    for (int i = 0; i < 7; i++) begin
      op(4'h4, 12'h000, 8'h00); rd_stat();
    end
    op(4'hC, 12'h000, 8'h00); op(4'hC, 12'h001, 8'h00);
    repeat (2) @(posedge pclk);
    check(33'(last_addr), 33'(m_reg[1]));
    i_far.pulse_nmi(3);
    repeat (10) @(posedge pclk);
    push(); m_nret = m_mode; m_pc = NMI_VEC; m_mode = 2'b11;
    rd_stat();
    op(4'h8, 12'h000, 8'($random(seed))); rd_stat();
    // a second edge while already in nmi mode is held pending, not taken
    i_far.pulse_nmi(3);
    repeat (10) @(posedge pclk);
    rd(A_STAT, {12'h000, 1'b1, m_dep, m_z[m_mode], m_c[m_mode], m_mode, m_pc});
    // interrupt_exit leaves nmi mode, then the pending edge re-enters it at once
    op(4'h5, 12'h000, 8'h00);
    push(); m_nret = m_mode; m_pc = NMI_VEC; m_mode = 2'b11;
    rd_stat();
    op(4'h5, 12'h000, 8'h00); rd_stat();
    op(4'h1, 12'h456, 8'h00);
    do_reset();
    rd_stat();
    rd(regs[4], {24'h0, REG_RST});
    conclude();
  end
endmodule
`default_nettype wire

//--- verilog/ccc_core_ctrl.sv
/*
  core control: working registers, program counter, banked flags,
  six-level return stack and nmi entry, reached over apb.
  assumes a synchronous apb master and an nmi pin with pull-up.
*/
// Local design decision: the APB register port.
//Contract
//- 8-bit accumulator, data address FFh
//- pointer registers at 80h and 81h
//- short-direct slots at 82h and 83h
//- indirect access uses selected pointer as address
//- 12-bit program counter, 4096-byte space
//- pc sources: jump, call, branch, vectors, pop
//- relative branch adds offset through adder
//- three carry/zero pairs, one per mode
//- mode entry switches pair, return restores prior
//- pairs keep values across mode switches
//- only the active pair is visible
//- carry from carry/borrow, bit test, rotate
//- zero set when result equals zero
//- reset starts in nmi mode
//- six 12-bit stack levels outside data space
//- push shifts levels down, pc enters first
//- pop loads pc, shifts levels up
//- stack saturates full; empty return steps on
//- only pc is saved on stack
//- vectors at FFEh, FFCh and FF0h-FF7h
//- nmi falling edge synchronised before entry
//- low reset restarts through reset vector
`timescale 1ns/1ps
`default_nettype none
module ccc_core_ctrl #(
  parameter int STACK_DEPTH = 6 // return stack levels
) (
  input wire logic pclk, // 10 MHz bus and core clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high = write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic nmi_n, // top-priority interrupt pin, falling edge
  output logic [11:0] rom_addr, // next program rom address
  output logic [7:0] data_addr, // indirect data-space address
  output logic data_req // one-cycle indirect access strobe
);
  import ccc_pkg::*;

  // ==========================================================
  // state
  logic [7:0] acc_q; // accumulator
  logic [7:0] wreg_q [4]; // pointers and short-direct slots
  logic [11:0] pc_q; // program counter
  logic [11:0] stk_q [STACK_DEPTH]; // return stack, not in data space
  logic [2:0] depth_q; // filled stack levels
  ccc_mode_type mode_q; // active mode
  ccc_mode_type nmi_prev_q; // mode to resume after nmi exit
  logic [2:0] carry_q; // carry per mode: main, irq, nmi
  logic [2:0] zero_q; // zero per mode
  logic nmi_s1_q, nmi_s2_q, nmi_s3_q; // pin synchroniser and edge stage
  logic nmi_pend_q; // falling edge seen, not yet taken
  logic pready_q, pslverr_q; // bus answer
  logic [31:0] prdata_q; // read data
  logic [7:0] daddr_q; // indirect address
  logic dreq_q; // indirect strobe

  // ==========================================================
  // bus decode
  logic [9:0] idx; // register index
  logic wr_go; // write takes effect at this edge
  logic cmd_go; // command executes at this edge
  ccc_cmd_type cmd; // decoded command
  assign idx = paddr[11:2];
  assign wr_go = psel & penable & pready_q & pwrite;
  assign cmd_go = wr_go & (idx == IDX_CMD);
  assign cmd = ccc_cmd_type'(pwdata[23:0]);

  // active flag pair index
  logic [1:0] mi; // 0 main, 1 irq, 2 nmi
  logic [2:0] act_mask; // one-hot of active pair
  always_comb begin
    case (mode_q)
      MODE_IRQ: mi = 2'd1;
      MODE_NMI: mi = 2'd2;
      default: mi = 2'd0;
    endcase
    act_mask = 3'b001 << mi;
  end

  // ==========================================================
  // sequencing: nmi waits one cycle if a command is running, and is
  // not re-entered while already in nmi mode
  logic nmi_take, push, pop, is_ret;
  assign nmi_take = nmi_pend_q & ~cmd_go & (mode_q != MODE_NMI);
  assign is_ret = (cmd.op == OP_RET) | (cmd.op == OP_INTERRUPT_EXIT);
  assign push = nmi_take | cmd_go & ((cmd.op == OP_CALL) |
                ((cmd.op == OP_IRQ) & (mode_q == MODE_MAIN)));
  assign pop = cmd_go & is_ret & (depth_q != 3'd0);

  // branch target through the adder, offset is signed 8-bit
  logic [11:0] br_sum;
  assign br_sum = pc_q + {{4{cmd.arg[7]}}, cmd.arg[7:0]};

  // ==========================================================
  // alu: result, carry and zero for the active pair
  logic [7:0] alu_r; // result
  logic alu_c, alu_wc, alu_wz, alu_wa; // carry and write enables
  always_comb begin
    alu_r = acc_q;
    alu_c = carry_q[mi];
    alu_wc = 1'b0;
    alu_wz = 1'b0;
    alu_wa = 1'b0;
    case (cmd.op)
      OP_ADD: begin
        {alu_c, alu_r} = {1'b0, acc_q} + {1'b0, cmd.data};
        alu_wc = 1'b1;
        alu_wz = 1'b1;
        alu_wa = 1'b1;
      end
      OP_SUB: begin
        {alu_c, alu_r} = {1'b0, acc_q} - {1'b0, cmd.data};
        alu_wc = 1'b1;
        alu_wz = 1'b1;
        alu_wa = 1'b1;
      end
      OP_AND: begin
        alu_r = acc_q & cmd.data;
        alu_wz = 1'b1;
        alu_wa = 1'b1;
      end
      OP_BTST: begin
        alu_c = cmd.data[cmd.arg[2:0]];
        alu_wc = 1'b1;
      end
      OP_RLC: begin
        alu_r = {acc_q[6:0], carry_q[mi]};
        alu_c = acc_q[7];
        alu_wc = 1'b1;
        alu_wz = 1'b1;
        alu_wa = 1'b1;
      end
      default: begin
        alu_r = acc_q;
      end
    endcase
  end

  // ==========================================================
  // accumulator: bus write or alu result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= REG_RST;
    end else if (cmd_go & alu_wa) begin
      acc_q <= alu_r;
    end else if (wr_go & (idx == IDX_ACC)) begin
      acc_q <= pwdata[7:0];
    end
  end

  // pointer and slot registers, plain data-space bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        wreg_q[i] <= REG_RST;
      end
    end else if (wr_go & (idx[9:2] == IDX_PTR_FIRST[9:2])) begin
      wreg_q[idx[1:0]] <= pwdata[7:0];
    end
  end

  // indirect access: the pointer's content is the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      daddr_q <= 8'h00;
      dreq_q <= 1'b0;
    end else begin
      dreq_q <= cmd_go & (cmd.op == OP_IND);
      if (cmd_go & (cmd.op == OP_IND)) begin
        daddr_q <= wreg_q[{1'b0, cmd.arg[0]}];
      end
    end
  end

  // ==========================================================
  // program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= RESET_VEC;
    end else if (nmi_take) begin
      pc_q <= NMI_VEC;
    end else if (cmd_go) begin
      case (cmd.op)
        OP_JUMP, OP_CALL: pc_q <= cmd.arg;
        OP_BRANCH: pc_q <= br_sum;
        OP_IRQ: begin
          // irq is ignored outside main mode, core just steps
          if (mode_q == MODE_MAIN) begin
            pc_q <= IRQ_VEC_BASE + {9'h000, cmd.arg[1:0], 1'b0};
          end else begin
            pc_q <= pc_q + 12'h001;
          end
        end
        OP_RET, OP_INTERRUPT_EXIT: begin
          // empty stack: carry on with the next instruction
          pc_q <= (depth_q != 3'd0) ? stk_q[0] : pc_q + 12'h001;
        end
        default: pc_q <= pc_q + 12'h001;
      endcase
    end
  end

  // ==========================================================
  // return stack: shift register, only the pc goes in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk_q[i] <= 12'h000;
      end
    end else if (push) begin
      stk_q[0] <= pc_q;
      for (int i = 1; i < STACK_DEPTH; i++) begin
        stk_q[i] <= stk_q[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        stk_q[i] <= stk_q[i+1];
      end
    end
  end

  // fill level saturates at both ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth_q <= 3'd0;
    end else if (push & (depth_q != 3'(STACK_DEPTH))) begin
      depth_q <= depth_q + 3'd1;
    end else if (pop) begin
      depth_q <= depth_q - 3'd1;
    end
  end

  // ==========================================================
  // mode: nmi from anywhere else, irq from main, interrupt_exit goes back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_NMI;
      nmi_prev_q <= MODE_MAIN;
    end else if (nmi_take) begin
      mode_q <= MODE_NMI;
      nmi_prev_q <= mode_q;
    end else if (cmd_go & (cmd.op == OP_IRQ) & (mode_q == MODE_MAIN)) begin
      mode_q <= MODE_IRQ;
    end else if (cmd_go & (cmd.op == OP_INTERRUPT_EXIT)) begin
      mode_q <= (mode_q == MODE_NMI) ? nmi_prev_q : MODE_MAIN;
    end
  end

  // flag pairs: only the active one is written, none cleared on switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 3'b000;
      zero_q <= 3'b000;
    end else if (cmd_go) begin
      if (alu_wc) begin
        carry_q[mi] <= alu_c;
      end
      if (alu_wz) begin
        zero_q[mi] <= (alu_r == 8'h00);
      end
    end
  end

  // ==========================================================
  // nmi pin: two-flop synchroniser, edge stage behind it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_s1_q <= 1'b1;
      nmi_s2_q <= 1'b1;
      nmi_s3_q <= 1'b1;
    end else begin
      nmi_s1_q <= nmi_n;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  // pending flag: a new edge wins over the take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_s3_q & ~nmi_s2_q) begin
      nmi_pend_q <= 1'b1;
    end else if (nmi_take) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // ==========================================================
  // apb answer: ready one cycle after setup, data captured at setup
  ccc_stat_type stat;
  logic [31:0] rd_d;
  logic err_d;
  always_comb begin
    stat = '{nmi_pend: nmi_pend_q, depth: depth_q, zero: zero_q[mi],
             carry: carry_q[mi], mode: mode_q, pc: pc_q};
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (idx)
      IDX_ACC: rd_d = {24'h000000, acc_q};
      IDX_PTR_FIRST, IDX_PTR_SECOND, IDX_SLOT_A, IDX_SLOT_B:
        rd_d = {24'h000000, wreg_q[idx[1:0]]};
      IDX_CMD: rd_d = 32'h0000_0000; // write only
      IDX_STAT: rd_d = {12'h000, stat};
      IDX_STACK: rd_d = {20'h00000, stk_q[0]};
      default: err_d = 1'b1; // unmapped
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & err_d;
      prdata_q <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rom_addr = pc_q;
  assign data_addr = daddr_q;
  assign data_req = dreq_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_nmi_fall;
    nmi_s3_q && !nmi_s2_q;
  endsequence
  sequence s_nmi_free;
    nmi_pend_q && (mode_q != MODE_NMI) && !cmd_go;
  endsequence

  AST_NMI_ENTRY: assert property (s_nmi_fall ##1 s_nmi_free |=>
    (mode_q == MODE_NMI) && (pc_q == NMI_VEC) && (stk_q[0] == $past(pc_q)))
    else $error("nmi entry not taken");
  AST_IRQ_ENTRY: assert property (cmd_go && cmd.op == OP_IRQ &&
    mode_q == MODE_MAIN |=> mode_q == MODE_IRQ && pc_q[11:3] == IRQ_VEC_BASE[11:3])
    else $error("irq entry wrong");
  AST_INTERRUPT_EXIT_MODE: assert property (cmd_go && cmd.op == OP_INTERRUPT_EXIT &&
    mode_q == MODE_NMI |=> mode_q == $past(nmi_prev_q))
    else $error("interrupt_exit did not restore mode");
  AST_PUSH: assert property (push && !nmi_take |=>
    stk_q[0] == $past(pc_q) && stk_q[1] == $past(stk_q[0]))
    else $error("push shift wrong");
  AST_POP: assert property (pop |=> pc_q == $past(stk_q[0]) &&
    depth_q == $past(depth_q) - 3'd1)
    else $error("pop wrong");
  AST_EMPTY_RET: assert property (cmd_go && is_ret && depth_q == 3'd0 |=>
    pc_q == $past(pc_q) + 12'h001 && depth_q == 3'd0)
    else $error("return on empty stack wrong");
  AST_DEPTH_MAX: assert property (depth_q <= STACK_LEVELS)
    else $error("stack depth above six");
  AST_BRANCH: assert property (cmd_go && cmd.op == OP_BRANCH && !nmi_take |=>
    pc_q == $past(pc_q) + {{4{$past(cmd.arg[7])}}, $past(cmd.arg[7:0])})
    else $error("branch target wrong");
  AST_FLAG_KEEP: assert property ((mode_q != $past(mode_q)) |->
    carry_q == $past(carry_q) && zero_q == $past(zero_q))
    else $error("flags changed on mode switch");
  AST_OTHER_PAIRS: assert property
    ((((carry_q ^ $past(carry_q)) | (zero_q ^ $past(zero_q))) & ~$past(act_mask)) == 3'b000)
    else $error("inactive flag pair written");
  AST_ZERO: assert property (cmd_go && cmd.op == OP_ADD |=>
    zero_q[$past(mi)] == (acc_q == 8'h00))
    else $error("zero flag wrong");
  AST_APB_READY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready timing wrong");
endmodule
`default_nettype wire

//--- verilog/ccc_pkg.sv
/*
  constants, types and register map of the core control block.
  assumes a 32-bit apb slave port with a 12-bit byte address.
*/
`default_nettype none
package ccc_pkg;
  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [9:0] IDX_PTR_FIRST = 10'h080; // pointer_first_reg
  localparam logic [9:0] IDX_PTR_SECOND = 10'h081; // pointer_second_reg
  localparam logic [9:0] IDX_SLOT_A = 10'h082; // short_slot_a_reg
  localparam logic [9:0] IDX_SLOT_B = 10'h083; // short_slot_b_reg
  localparam logic [9:0] IDX_ACC = 10'h0FF; // accumulator_reg
  localparam logic [9:0] IDX_CMD = 10'h100; // command register, write only
  localparam logic [9:0] IDX_STAT = 10'h101; // status register, read only
  localparam logic [9:0] IDX_STACK = 10'h102; // first stack level, read only
  localparam logic [7:0] REG_RST = 8'h00; // data registers after reset

  // ==========================================================
  // program space vectors
  localparam logic [11:0] RESET_VEC = 12'hFFE;
  localparam logic [11:0] NMI_VEC = 12'hFFC;
  localparam logic [11:0] IRQ_VEC_BASE = 12'hFF0; // four 2-byte vectors
  localparam logic [2:0] STACK_LEVELS = 3'h6;

  // ==========================================================
  // command codes and core modes
  typedef enum logic [3:0] {
    OP_STEP = 4'h0, OP_JUMP = 4'h1, OP_CALL = 4'h2, OP_BRANCH = 4'h3,
    OP_RET = 4'h4, OP_INTERRUPT_EXIT = 4'h5, OP_IRQ = 4'h6, OP_ADD = 4'h7,
    OP_SUB = 4'h8, OP_AND = 4'h9, OP_BTST = 4'hA, OP_RLC = 4'hB,
    OP_IND = 4'hC
  } ccc_op_type;

  // gray along main -> irq -> nmi
  typedef enum logic [1:0] {
    MODE_MAIN = 2'b00, MODE_IRQ = 2'b01, MODE_NMI = 2'b11
  } ccc_mode_type;

  // command word as written into pwdata[23:0]
  typedef struct packed {
    logic [7:0] data;
    logic [11:0] arg;
    ccc_op_type op;
  } ccc_cmd_type;

  // status word as read from prdata[19:0]
  typedef struct packed {
    logic nmi_pend;
    logic [2:0] depth;
    logic zero;
    logic carry;
    ccc_mode_type mode;
    logic [11:0] pc;
  } ccc_stat_type;
endpackage
`default_nettype wire
